// file: irqf_consts.svh
// Offsets, field positions, reset values and timing counts of the request-flag block
//------------------------------------------------------------
//------------------------------------------------------------
`ifndef IRQF_CONSTS_SVH
`define IRQF_CONSTS_SVH

// Register byte offsets
`define IRQF_OFS_PINCTL 8'h00
`define IRQF_OFS_ALLOW_A 8'h04
`define IRQF_OFS_ALLOW_B 8'h08
`define IRQF_OFS_TMRFLG 8'h0C
`define IRQF_OFS_ARRA_FLG 8'h10
`define IRQF_OFS_ARRA_EN 8'h14
`define IRQF_OFS_ARRB_FLG 8'h18
`define IRQF_OFS_ARRB_EN 8'h1C
`define IRQF_OFS_REQ 8'h20

// Field positions
`define IRQF_ALLOW_A_PIN0 0
`define IRQF_ALLOW_A_TMR0 1
`define IRQF_ALLOW_A_PIN1 2
`define IRQF_ALLOW_A_TMR1 3
`define IRQF_ALLOW_A_TMR2 5
`define IRQF_ALLOW_A_ARRA 6
`define IRQF_ALLOW_A_GATE 7
`define IRQF_ALLOW_B_ARRB 1
`define IRQF_ARR_WRAP 5

// Reset values
`define IRQF_RST_BYTE 8'h00

// Timing: oscillator periods per machine cycle, reference clocks per period
`define IRQF_OSC_PER_MC 12
`define IRQF_REF_PER_OSC 1
`define IRQF_MC_CYC (`IRQF_OSC_PER_MC * `IRQF_REF_PER_OSC)

`endif

// file: irqf_pkg.sv
// Types of the request-flag block
package irqf_pkg;

    // Whole state of the block
    typedef struct packed {
        logic [6:0] pin_s1;         // Synchroniser stage one
        logic [6:0] pin_s2;         // Synchroniser stage two
        logic [6:0] pin_smp;        // Pin levels at last machine-cycle sample
        logic primed;               // First sample taken
        logic [3:0] mc_cnt;         // Machine-cycle phase
        logic [6:0] lat;            // Request latches 0..6
        logic [1:0] pol;            // Polarity selects of pins 2, 3
        logic [1:0] trig;           // Trigger types of pins 0, 1
        logic [7:0] allow_a;        // Main enable register
        logic [7:0] allow_b;        // Auxiliary enable register
        logic [3:0] tmr;            // Timer 0, 1, 2 rollover, timer 2 capture
        logic [1:0][5:0] arr_flg;   // Array match flags and wrap flag
        logic [1:0][5:0] arr_en;    // Array match and wrap enables
        logic [11:0] req;           // Forwarded requests
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } irqf_state_t;

endpackage

// file: irqf_flags.sv
// Interrupt request-flag front end with APB register access
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "irqf_consts.svh"

module irqf_flags (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // External pins, asynchronous
    input wire logic [6:0] i_pin_irq,
    // Timer set pulses
    input wire logic i_tmr0_roll,
    input wire logic i_tmr0_alt_roll,
    input wire logic i_tmr0_mode3,
    input wire logic i_tmr1_roll,
    input wire logic i_tmr2_roll,
    input wire logic i_tmr2_capture,
    // Counter-array set pulses
    input wire logic [4:0] i_match_a_set,
    input wire logic i_wrap_a_set,
    input wire logic [4:0] i_match_b_set,
    input wire logic i_wrap_b_set,
    // CPU vectoring
    input wire logic [11:0] i_vec_ack,
    output logic [11:0] o_irq_req
);

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    localparam logic [3:0] MC_LAST = 4'(`IRQF_MC_CYC - 1);

    irqf_pkg::irqf_state_t r;   // Registered state
    irqf_pkg::irqf_state_t s;   // Next state

    //------------------------------------------------------------
    // Next-state logic
    //------------------------------------------------------------
    always_comb begin
        logic tick;
        logic wr;
        logic setup;
        logic [6:0] rise;
        logic [6:0] fall;
        logic [6:0] edg;
        logic [6:0] pin_allow;
        logic [3:0] tset;
        logic [1:0][5:0] aset;
        logic [11:0] raw;
        logic [7:0] wb;
        logic [1:0] arr_req;
        logic level;                // Pin 0/1 in level mode
        tick = 1'b0;
        wr = 1'b0;
        setup = 1'b0;
        rise = 7'h00;
        fall = 7'h00;
        edg = 7'h00;
        pin_allow = 7'h00;
        tset = 4'h0;
        aset = '0;
        raw = 12'h000;
        wb = i_pwdata[7:0];
        arr_req = 2'b00;
        level = 1'b0;
        s = r;

        // Synchroniser; stage one feeds only stage two
        s.pin_s1 = i_pin_irq;
        s.pin_s2 = r.pin_s1;

        // Machine-cycle divider and once-per-cycle pin sample
        tick = (r.mc_cnt == MC_LAST);
        s.mc_cnt = tick ? 4'h0 : r.mc_cnt + 4'h1;
        if (tick) begin
            s.pin_smp = r.pin_s2;
            s.primed = 1'b1;
            if (r.primed) begin
                rise = r.pin_s2 & ~r.pin_smp;
                fall = ~r.pin_s2 & r.pin_smp;
            end
        end

        // Qualifying edge per pin
        edg[0] = fall[0];
        edg[1] = fall[1];
        edg[2] = r.pol[0] ? rise[2] : fall[2];
        edg[3] = r.pol[1] ? rise[3] : fall[3];
        edg[6:4] = rise[6:4];

        // Write strobe at the access edge
        wr = i_psel & i_penable & r.pready & i_pwrite;
        setup = i_psel & ~i_penable;

        // Software writes to control and flag registers
        if (wr) begin
            case (i_paddr)
                `IRQF_OFS_PINCTL: begin
                    s.lat[6:2] = wb[6:2];
                    s.pol = wb[1:0];
                end
                `IRQF_OFS_ALLOW_A: begin
                    s.allow_a = wb;
                end
                `IRQF_OFS_ALLOW_B: begin
                    s.allow_b = wb;
                end
                `IRQF_OFS_TMRFLG: begin
                    s.trig = {wb[2], wb[0]};
                    s.lat[1:0] = {wb[3], wb[1]};
                    s.tmr = wb[7:4];
                end
                `IRQF_OFS_ARRA_FLG: begin
                    s.arr_flg[0] = wb[5:0];
                end
                `IRQF_OFS_ARRA_EN: begin
                    s.arr_en[0] = wb[5:0];
                end
                `IRQF_OFS_ARRB_FLG: begin
                    s.arr_flg[1] = wb[5:0];
                end
                `IRQF_OFS_ARRB_EN: begin
                    s.arr_en[1] = wb[5:0];
                end
                default: begin
                end
            endcase
        end

        // Pin latches: level mode follows the sampled pin; otherwise vector clear, then hardware set wins
        for (int i = 0; i < 7; i++) begin
            // Only pins 0 and 1 have a trigger type; no select past bit 1
            level = (i < 2) ? ~s.trig[i[0]] : 1'b0;
            if (level) begin
                // No request before the first sample: pins are not yet known
                s.lat[i] = s.primed & ~s.pin_smp[i];
            end else begin
                if (i_vec_ack[i]) begin
                    s.lat[i] = 1'b0;
                end
                if (edg[i]) begin
                    s.lat[i] = 1'b1;
                end
            end
        end

        // Timer flags; timer 0 in mode 3 takes the alternate pulse
        tset[0] = i_tmr0_mode3 ? i_tmr0_alt_roll : i_tmr0_roll;
        tset[1] = i_tmr1_roll;
        tset[2] = i_tmr2_roll;
        tset[3] = i_tmr2_capture;
        for (int i = 0; i < 4; i++) begin
            if (i < 2 && i_vec_ack[7 + i]) begin
                s.tmr[i] = 1'b0;
            end
            if (tset[i]) begin
                s.tmr[i] = 1'b1;
            end
        end

        // Array flags; no vector clear
        aset[0] = {i_wrap_a_set, i_match_a_set};
        aset[1] = {i_wrap_b_set, i_match_b_set};
        for (int a = 0; a < 2; a++) begin
            s.arr_flg[a] = s.arr_flg[a] | aset[a];
            arr_req[a] = |(s.arr_flg[a] & s.arr_en[a]);
        end

        // Raw requests from the next state
        pin_allow = {s.allow_b[6:2], s.allow_a[`IRQF_ALLOW_A_PIN1],
                     s.allow_a[`IRQF_ALLOW_A_PIN0]};
        raw[6:0] = s.lat & pin_allow;
        raw[7] = s.tmr[0] & s.allow_a[`IRQF_ALLOW_A_TMR0];
        raw[8] = s.tmr[1] & s.allow_a[`IRQF_ALLOW_A_TMR1];
        raw[9] = (s.tmr[2] | s.tmr[3]) & s.allow_a[`IRQF_ALLOW_A_TMR2];
        raw[10] = arr_req[0] & s.allow_a[`IRQF_ALLOW_A_ARRA];
        raw[11] = arr_req[1] & s.allow_b[`IRQF_ALLOW_B_ARRB];
        s.req = s.allow_a[`IRQF_ALLOW_A_GATE] ? raw : 12'h000;

        // APB answer prepared in the setup cycle
        s.pready = setup;
        if (setup) begin
            s.pslverr = 1'b0;
            s.prdata = 32'h0000_0000;
            case (i_paddr)
                `IRQF_OFS_PINCTL: begin
                    s.prdata[6:0] = {r.lat[6:2], r.pol};
                end
                `IRQF_OFS_ALLOW_A: begin
                    s.prdata[7:0] = r.allow_a;
                end
                `IRQF_OFS_ALLOW_B: begin
                    s.prdata[7:0] = r.allow_b;
                end
                `IRQF_OFS_TMRFLG: begin
                    // Same bit map as the write: trigger type below its latch
                    s.prdata[7:0] = {r.tmr, r.lat[1], r.trig[1], r.lat[0], r.trig[0]};
                end
                `IRQF_OFS_ARRA_FLG: begin
                    s.prdata[5:0] = r.arr_flg[0];
                end
                `IRQF_OFS_ARRA_EN: begin
                    s.prdata[5:0] = r.arr_en[0];
                end
                `IRQF_OFS_ARRB_FLG: begin
                    s.prdata[5:0] = r.arr_flg[1];
                end
                `IRQF_OFS_ARRB_EN: begin
                    s.prdata[5:0] = r.arr_en[1];
                end
                `IRQF_OFS_REQ: begin
                    s.prdata[11:0] = r.req;
                end
                default: begin
                    s.pslverr = 1'b1;
                end
            endcase
        end else begin
            s.pslverr = 1'b0;
        end
    end

    //------------------------------------------------------------
    // State register
    //------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            r <= '0;
        end else begin
            r <= s;
        end
    end

    //------------------------------------------------------------
    // Outputs straight from flip-flops
    //------------------------------------------------------------
    assign o_prdata = r.prdata;
    assign o_pready = r.pready;
    assign o_pslverr = r.pslverr;
    assign o_irq_req = r.req;

endmodule

// file: irqf_flags_assertions.sv
// Port checker of the request-flag block, bound into its top module
`timescale 1ns/1ps
module irqf_flags_chk (
    // Clock, reset and bus requests
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [7:0] i_paddr,
    // Events and answers
    input wire logic i_tmr1_roll,
    input wire logic [11:0] i_vec_ack,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [11:0] o_irq_req
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    //----------------------------------------
    // Bus answers
    //----------------------------------------
    a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (o_pready |=> !o_pready) else $error("ready held");
    a_err_unmapped: assert property (i_psel && !i_penable && i_paddr > 8'h20
        |=> o_pslverr && o_prdata == 32'h0) else $error("unmapped access not refused");
    a_upper_zero: assert property (o_pready && i_paddr != 8'h20 |-> o_prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_req_upper_zero: assert property (o_pready |-> o_prdata[31:12] == 20'h0)
        else $error("request word upper bits set");
    //----------------------------------------
    // Request flags
    //----------------------------------------
    a_tmr1_rise_cause: assert property ($rose(o_irq_req[8]) |->
        $past(i_tmr1_roll) || $past(i_psel)) else $error("timer 1 request without cause");
    a_tmr1_vec_clear: assert property (i_vec_ack[8] && !i_tmr1_roll && !i_psel
        |=> !o_irq_req[8]) else $error("timer 1 flag kept after vector");
    a_set_beats_clear: assert property (o_irq_req[8] && i_vec_ack[8] && i_tmr1_roll
        && !i_psel |=> o_irq_req[8]) else $error("new set lost to vector clear");
    a_tmr2_held: assert property (o_irq_req[9] && !i_psel |=> o_irq_req[9])
        else $error("timer 2 request dropped by hardware");
    a_array_held: assert property (!i_psel |=>
        ($past(o_irq_req[11:10]) & ~o_irq_req[11:10]) == 2'h0)
        else $error("array request dropped by hardware");
    // Main scenarios reached
    c_vec_tmr1: cover property (i_vec_ack[8] && o_irq_req[8]);
    c_refused: cover property (o_pslverr);
    c_pin3_req: cover property ($rose(o_irq_req[3]));
endmodule

bind irqf_flags irqf_flags_chk u_chk (.*);

// file: irqf_src_model.sv
// External request sources and CPU vectoring side of the request-flag block
`timescale 1ns/1ps
module irqf_src_model (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Bench commands: pin levels, vectored sources, vector delay
    input wire logic [6:0] i_pin_cmd,
    input wire logic [11:0] i_ack_en,
    input wire logic [2:0] i_delay,
    // Block side
    input wire logic [11:0] i_irq_req,
    output logic [6:0] o_pin_irq,
    output logic [11:0] o_vec_ack
);
    logic [6:0] pin_r; // Driven pin levels
    logic [2:0] wait_r; // Cycles a served request has waited
    logic [11:0] ack_r; // Vector pulses
    // Idle pins sit high; no vector during reset
    assign o_pin_irq = i_rstn ? pin_r : 7'h7F;
    assign o_vec_ack = i_rstn ? ack_r : 12'h000;
    // Bench holds each level for two machine cycles or more
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_r <= 7'h7F;
            wait_r <= 3'h0;
            ack_r <= 12'h000;
        end else begin
            pin_r <= i_pin_cmd;
            wait_r <= (|(i_irq_req & i_ack_en)) ? wait_r + 3'h1 : 3'h0;
            ack_r <= (wait_r == i_delay) ? (i_irq_req & i_ack_en) : 12'h000;
        end
    end
endmodule

// file: testbench.sv
// Self-checking bench of the request-flag block
`timescale 1ns/1ps
module testbench;
    logic i_ref_clk = 1'h0;
    logic i_rstn = 1'h0;
    logic i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rdv;
    logic o_pready, o_pslverr;
    logic [6:0] pc = 7'h7F, i_pin_irq;
    logic [11:0] ack_en = 12'h000, tbk = 12'h000, pack, i_vec_ack, o_irq_req;
    logic [2:0] dly = 3'h0;
    logic [15:0] ev = 16'h0000; // Timer and array set pulses
    logic m3 = 1'h0, alt = 1'h0; // Timer 0 mode 3 and its alternate roll
    int bad_count = 0, checks = 0;
    assign i_vec_ack = pack | tbk;
    initial begin
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end
    irqf_flags DUT (.*, .i_tmr0_roll(ev[0]), .i_tmr0_alt_roll(alt), .i_tmr0_mode3(m3),
        .i_tmr1_roll(ev[1]), .i_tmr2_roll(ev[2]), .i_tmr2_capture(ev[3]),
        .i_match_a_set(ev[8:4]), .i_wrap_a_set(ev[9]), .i_match_b_set(ev[14:10]),
        .i_wrap_b_set(ev[15]));
    irqf_src_model u_src (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_pin_cmd(pc),
        .i_ack_en(ack_en), .i_delay(dly), .i_irq_req(o_irq_req), .o_pin_irq(i_pin_irq),
        .o_vec_ack(pack));
    //----------------------------------------
    // Tasks
    //----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t ns: got %h, want %h", $time, g, e);
        end
    endtask
    task automatic rq(input logic [11:0] e);
        cyc(4);
        chk({20'h0, o_irq_req}, {20'h0, e});
    endtask
    // Bus cycle; bit 31 of rdv carries the refusal, read data leaves it zero
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        i_psel <= 1'h1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= {24'h0, d};
        @(posedge i_ref_clk);
        i_penable <= 1'h1;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_pready !== 1'h1 && n < 50);
        rdv = o_prdata | {o_pslverr, 31'h0};
        if (n >= 50) bad_count++;
        i_psel <= 1'h0;
        i_penable <= 1'h0;
        cyc(1);
    endtask
    task automatic pulse(input logic [15:0] m, input logic [11:0] k);
        ev <= m;
        tbk <= k;
        @(posedge i_ref_clk);
        ev <= 16'h0000;
        tbk <= 12'h000;
        // Let the cleared pulse reach an edge before the next call
        @(posedge i_ref_clk);
    endtask
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Watchdog well beyond the few hundred cycles of the tests
    initial begin
        cyc(20000);
        bad_count++;
        wrap_up();
    end
    //----------------------------------------
    // Tests
    //----------------------------------------
    initial begin
        cyc(12);
        i_rstn <= 1'h1;
        apb(1'h0, 8'h00, 8'h00);
        chk(rdv, 32'h0);
        apb(1'h1, 8'h04, 8'hFF);
        apb(1'h1, 8'h08, 8'h7E);
        apb(1'h0, 8'h04, 8'h00);
        chk(rdv, 32'hFF);
        apb(1'h0, 8'h24, 8'h00);
        chk(rdv, 32'h8000_0000);
        // Timers
        apb(1'h1, 8'h04, 8'h7F);
        pulse(16'h0002, 12'h000);
        rq(12'h000);
        apb(1'h1, 8'h04, 8'hFF);
        rq(12'h100);
        ack_en <= 12'h100;
        rq(12'h000);
        pulse(16'h0001, 12'h000);
        rq(12'h080);
        m3 <= 1'h1;
        pulse(16'h0001, 12'h080);
        rq(12'h000);
        alt <= 1'h1;
        cyc(1);
        alt <= 1'h0;
        m3 <= 1'h0;
        rq(12'h080);
        pulse(16'h0004, 12'h000);
        ack_en <= 12'h200;
        cyc(20);
        rq(12'h280);
        ack_en <= 12'h000;
        apb(1'h1, 8'h0C, 8'h00);
        rq(12'h000);
        apb(1'h1, 8'h04, 8'hDF);
        pulse(16'h0008, 12'h000);
        rq(12'h000);
        apb(1'h1, 8'h04, 8'hFF);
        rq(12'h200);
        apb(1'h1, 8'h0C, 8'h00);
        pulse(16'h0002, 12'h000);
        pulse(16'h0002, 12'h100);
        rq(12'h100);
        pulse(16'h0000, 12'h100);
        rq(12'h000);
        // Pins 2 to 6: pin 3 rising, pin 2 falling
        apb(1'h1, 8'h00, 8'h02);
        pc <= 7'h03;
        cyc(30);
        rq(12'h004);
        pc <= 7'h7F;
        cyc(30);
        rq(12'h07C);
        dly <= 3'h5;
        ack_en <= 12'h07C;
        rq(12'h07C);
        cyc(8);
        rq(12'h000);
        ack_en <= 12'h000;
        apb(1'h1, 8'h00, 8'h12);
        rq(12'h010);
        apb(1'h0, 8'h00, 8'h00);
        chk(rdv, 32'h12);
        // Pin 0 in level mode, then falling edge
        pc <= 7'h7E;
        cyc(30);
        rq(12'h011);
        pulse(16'h0000, 12'h001);
        rq(12'h011);
        pc <= 7'h7F;
        cyc(30);
        rq(12'h010);
        apb(1'h1, 8'h0C, 8'h01);
        apb(1'h0, 8'h0C, 8'h00);
        chk(rdv, 32'h01);
        pc <= 7'h7E;
        cyc(30);
        pc <= 7'h7F;
        cyc(30);
        rq(12'h011);
        pulse(16'h0000, 12'h011);
        rq(12'h000);
        // Counter arrays
        apb(1'h1, 8'h14, 8'h20);
        pulse(16'h0010, 12'h000);
        rq(12'h000);
        pulse(16'h0200, 12'h000);
        pulse(16'h0000, 12'h400);
        rq(12'h400);
        apb(1'h1, 8'h04, 8'hBF);
        rq(12'h000);
        apb(1'h1, 8'h04, 8'hFF);
        apb(1'h1, 8'h10, 8'h00);
        rq(12'h000);
        apb(1'h1, 8'h1C, 8'h10);
        apb(1'h0, 8'h1C, 8'h00);
        chk(rdv, 32'h10);
        pulse(16'hC000, 12'h000);
        rq(12'h800);
        apb(1'h0, 8'h20, 8'h00);
        chk(rdv, 32'h800);
        wrap_up();
    end
endmodule
